// >>> hw/pin_io_controller.sv
// Parallel pin I/O controller with Avalon-MM register slave
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/100ps

// Overview of operation
// RL1 - Each pin is owned either by its peripheral or by general-purpose control.
// RL2 - Enable-command ones hand pins to general-purpose control.
// RL3 - Disable-command ones return pins to their peripheral.
// RL4 - Peripheral A and B select commands choose which peripheral drives a pin.
// RL5 - Output-enable ones make pins outputs; output-disable ones make inputs.
// RL6 - Each pin has its own pull-up, all on after reset.
// RL7 - Pull-up off command ones switch that pin's pull-up off.
// RL8 - Set-output ones drive pins high; clear-output ones drive them low.
// RL9 - Pin level status reads the real level of each pin.
// RL10 - Rising and falling edges on any pin are both detected.
// RL11 - Interrupt-enable ones let a pin's change raise the interrupt.
// RL12 - Change status reports pins changed since it was last read.
// RL13 - Reading change status clears the flags and acknowledges the interrupt.
// RL14 - Interrupt output is a level held until acknowledged.
// RL15 - Software enables this block's clock before relying on sampling.
// RL16 - Zero bits in any command write leave pin settings unchanged.
// RL17 - Interrupt is high while any enabled pin has a change flag set.
module pin_io_controller
  import pin_io_pkg::*;
#(
  parameter int PINS = pin_io_pkg::PIN_COUNT
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [pin_io_pkg::ADDR_WIDTH-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic [PINS-1:0] pinIn,
  output logic [PINS-1:0] pinOut,
  output logic [PINS-1:0] pinOe_n,
  output logic [PINS-1:0] pullupOn,
  input wire logic [PINS-1:0] periphAOut,
  input wire logic [PINS-1:0] periphAOe,
  input wire logic [PINS-1:0] periphBOut,
  input wire logic [PINS-1:0] periphBOe,
  output logic [PINS-1:0] periphIn
);
  import pin_io_pkg::*;

  // Elaboration check: one bus word holds every pin
  if (PINS < 1 || PINS > 32) begin
    $error("pin_io_controller supports 1 to 32 pins");
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Every access takes one wait cycle: request seen, then answered.
  bus_state_t busState_q;
  bus_state_t busState_d;
  logic [31:0] readdata_q;
  logic [31:0] readdata_d;
  logic newRead;
  logic newWrite;
  logic [31:0] wrMask;
  logic [PINS-1:0] wrBits;

  assign newRead = read && (busState_q == BUS_IDLE);
  assign newWrite = write && !read && (busState_q == BUS_IDLE);
  assign waitrequest = (read || write) && (busState_q == BUS_IDLE);
  assign wrMask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wrBits = PINS'(writedata & wrMask);
  assign readdata = readdata_q;

  always_comb begin
    busState_d = BUS_IDLE;
    if (newRead) begin
      busState_d = BUS_READ_DONE;
    end else if (newWrite) begin
      busState_d = BUS_WRITE_DONE;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire wrGpioEn = newWrite && (address == GPIO_ENABLE_CMD_OFS);
  wire wrGpioDis = newWrite && (address == GPIO_DISABLE_CMD_OFS);
  wire wrOutEn = newWrite && (address == OUTPUT_ENABLE_CMD_OFS);
  wire wrOutDis = newWrite && (address == OUTPUT_DISABLE_CMD_OFS);
  wire wrSetOut = newWrite && (address == SET_OUTPUT_CMD_OFS);
  wire wrClrOut = newWrite && (address == CLEAR_OUTPUT_CMD_OFS);
  wire wrIrqEn = newWrite && (address == CHANGE_IRQ_ENABLE_CMD_OFS);
  wire wrIrqDis = newWrite && (address == CHANGE_IRQ_DISABLE_CMD_OFS);
  wire wrPullOff = newWrite && (address == PULLUP_OFF_CMD_OFS);
  wire wrPullOn = newWrite && (address == PULLUP_ON_CMD_OFS);
  wire wrSelA = newWrite && (address == PERIPH_A_SELECT_CMD_OFS);
  wire wrSelB = newWrite && (address == PERIPH_B_SELECT_CMD_OFS);
  wire rdChangeStatus = newRead && (address == CHANGE_IRQ_STATUS_OFS);

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  logic [PINS-1:0] gpioOwned;
  logic [PINS-1:0] outEnabled;
  logic [PINS-1:0] outData;
  logic [PINS-1:0] irqMask;
  logic [PINS-1:0] pullups;
  logic [PINS-1:0] selB;

  cmd_bit_reg #(.WIDTH(PINS), .RESET_VALUE(PINS'(GPIO_RESET))) gpioReg ( // [RL2] [RL3] [RL16]
    .clock(clock), .arst_n(arst_n), .setStrobe(wrGpioEn), .clearStrobe(wrGpioDis),
    .wrData(wrBits), .value(gpioOwned));
  cmd_bit_reg #(.WIDTH(PINS), .RESET_VALUE(PINS'(OUTPUT_EN_RESET))) outEnReg ( // [RL5] [RL16]
    .clock(clock), .arst_n(arst_n), .setStrobe(wrOutEn), .clearStrobe(wrOutDis),
    .wrData(wrBits), .value(outEnabled));
  cmd_bit_reg #(.WIDTH(PINS), .RESET_VALUE(PINS'(OUTPUT_DATA_RESET))) outDataReg ( // [RL8] [RL16]
    .clock(clock), .arst_n(arst_n), .setStrobe(wrSetOut), .clearStrobe(wrClrOut),
    .wrData(wrBits), .value(outData));
  cmd_bit_reg #(.WIDTH(PINS), .RESET_VALUE(PINS'(IRQ_MASK_RESET))) irqMaskReg ( // [RL11] [RL17] [RL16]
    .clock(clock), .arst_n(arst_n), .setStrobe(wrIrqEn), .clearStrobe(wrIrqDis),
    .wrData(wrBits), .value(irqMask));
  cmd_bit_reg #(.WIDTH(PINS), .RESET_VALUE(PINS'(PULLUP_RESET))) pullReg ( // [RL6] [RL7] [RL16]
    .clock(clock), .arst_n(arst_n), .setStrobe(wrPullOn), .clearStrobe(wrPullOff),
    .wrData(wrBits), .value(pullups));
  cmd_bit_reg #(.WIDTH(PINS), .RESET_VALUE(PINS'(PERIPH_B_RESET))) selReg ( // [RL4] [RL16]
    .clock(clock), .arst_n(arst_n), .setStrobe(wrSelB), .clearStrobe(wrSelA),
    .wrData(wrBits), .value(selB));

  // ----------------------------------------------------------------
  // Pin multiplexing
  // ----------------------------------------------------------------
  // Peripheral path is combinational so peripheral timing is untouched
  wire [PINS-1:0] periphOut = (selB & periphBOut) | (~selB & periphAOut); // [RL4]
  wire [PINS-1:0] periphOe = (selB & periphBOe) | (~selB & periphAOe);
  wire [PINS-1:0] driveEn = (gpioOwned & outEnabled) | (~gpioOwned & periphOe); // [RL1] [RL5]

  assign pinOut = (gpioOwned & outData) | (~gpioOwned & periphOut); // [RL1] [RL8]
  assign pinOe_n = ~driveEn;
  assign pullupOn = pullups; // [RL6]
  assign periphIn = pinIn;

  // ----------------------------------------------------------------
  // Change detection and interrupt
  // ----------------------------------------------------------------
  // Sampling relies on the clock having been enabled upstream [RL15]
  logic [PINS-1:0] changeFlags;

  change_detect #(.WIDTH(PINS)) detector ( // [RL10] [RL12] [RL13]
    .clock(clock),
    .arst_n(arst_n),
    .pinLevel(pinIn),
    .clearAll(rdChangeStatus),
    .changeFlags(changeFlags)
  );

  // Level output, held until the status read clears the flags or the interrupt-disable command masks the pin
  assign irq = |(changeFlags & irqMask); // [RL14] [RL17]

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  logic [PINS-1:0] rdBits;
  logic rdHit;

  always_comb begin
    rdBits = '0;
    rdHit = 1'b1;
    case (address)
      GPIO_STATUS_OFS: rdBits = gpioOwned;
      OUTPUT_STATUS_OFS: rdBits = outEnabled;
      OUTPUT_DATA_STATUS_OFS: rdBits = outData;
      PIN_LEVEL_STATUS_OFS: rdBits = pinIn; // [RL9]
      CHANGE_IRQ_MASK_OFS: rdBits = irqMask;
      CHANGE_IRQ_STATUS_OFS: rdBits = changeFlags; // [RL12]
      PULLUP_STATUS_OFS: rdBits = pullups;
      PERIPH_SELECT_STATUS_OFS: rdBits = selB;
      default: rdHit = 1'b0;
    endcase
  end

  assign readdata_d = newRead ? (rdHit ? 32'(rdBits) : UNMAPPED_READ) : readdata_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busState_q <= BUS_IDLE;
      readdata_q <= 32'h00000000;
    end else begin
      busState_q <= busState_d;
      readdata_q <= readdata_d;
    end
  end
endmodule

// >>> hw/pin_io_pkg.sv
// Package: register map, reset values and widths for the pin I/O controller
package pin_io_pkg;
  localparam int PIN_COUNT = 32;
  localparam int ADDR_WIDTH = 8;
  localparam logic [ADDR_WIDTH-1:0] GPIO_ENABLE_CMD_OFS = 8'h00;
  localparam logic [ADDR_WIDTH-1:0] GPIO_DISABLE_CMD_OFS = 8'h04;
  localparam logic [ADDR_WIDTH-1:0] GPIO_STATUS_OFS = 8'h08;
  localparam logic [ADDR_WIDTH-1:0] OUTPUT_ENABLE_CMD_OFS = 8'h10;
  localparam logic [ADDR_WIDTH-1:0] OUTPUT_DISABLE_CMD_OFS = 8'h14;
  localparam logic [ADDR_WIDTH-1:0] OUTPUT_STATUS_OFS = 8'h18;
  localparam logic [ADDR_WIDTH-1:0] SET_OUTPUT_CMD_OFS = 8'h30;
  localparam logic [ADDR_WIDTH-1:0] CLEAR_OUTPUT_CMD_OFS = 8'h34;
  localparam logic [ADDR_WIDTH-1:0] OUTPUT_DATA_STATUS_OFS = 8'h38;
  localparam logic [ADDR_WIDTH-1:0] PIN_LEVEL_STATUS_OFS = 8'h3c;
  localparam logic [ADDR_WIDTH-1:0] CHANGE_IRQ_ENABLE_CMD_OFS = 8'h40;
  localparam logic [ADDR_WIDTH-1:0] CHANGE_IRQ_DISABLE_CMD_OFS = 8'h44;
  localparam logic [ADDR_WIDTH-1:0] CHANGE_IRQ_MASK_OFS = 8'h48;
  localparam logic [ADDR_WIDTH-1:0] CHANGE_IRQ_STATUS_OFS = 8'h4c;
  localparam logic [ADDR_WIDTH-1:0] PULLUP_OFF_CMD_OFS = 8'h60;
  localparam logic [ADDR_WIDTH-1:0] PULLUP_ON_CMD_OFS = 8'h64;
  localparam logic [ADDR_WIDTH-1:0] PULLUP_STATUS_OFS = 8'h68;
  localparam logic [ADDR_WIDTH-1:0] PERIPH_A_SELECT_CMD_OFS = 8'h70;
  localparam logic [ADDR_WIDTH-1:0] PERIPH_B_SELECT_CMD_OFS = 8'h74;
  localparam logic [ADDR_WIDTH-1:0] PERIPH_SELECT_STATUS_OFS = 8'h78;
  // Reset values: all pins to GPIO, inputs, pull-ups on, peripheral A
  localparam logic [31:0] GPIO_RESET = 32'hffffffff;
  localparam logic [31:0] OUTPUT_EN_RESET = 32'h00000000;
  localparam logic [31:0] OUTPUT_DATA_RESET = 32'h00000000;
  localparam logic [31:0] PULLUP_RESET = 32'hffffffff;
  localparam logic [31:0] PERIPH_B_RESET = 32'h00000000;
  localparam logic [31:0] IRQ_MASK_RESET = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_READ_DONE = 2'b01,
    BUS_WRITE_DONE = 2'b10
  } bus_state_t;
endpackage

// >>> hw/cmd_bit_reg.sv
// Set/clear command register: one-written bits set or clear, zeros keep state
`timescale 1ns/100ps
module cmd_bit_reg #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic setStrobe,
  input wire logic clearStrobe,
  input wire logic [WIDTH-1:0] wrData,
  output logic [WIDTH-1:0] value
);
  // Elaboration check: refuse widths the bus word cannot carry
  if (WIDTH < 1 || WIDTH > 32) begin
    $error("cmd_bit_reg width out of range");
  end

  logic [WIDTH-1:0] value_q;
  logic [WIDTH-1:0] value_d;

  assign value_d = setStrobe ? (value_q | wrData) :
                   clearStrobe ? (value_q & ~wrData) : value_q;
  assign value = value_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      value_q <= RESET_VALUE;
    end else begin
      value_q <= value_d;
    end
  end
endmodule

// >>> hw/change_detect.sv
// Per-pin level change detector with read-to-clear sticky flags
`timescale 1ns/100ps
module change_detect #(
  parameter int WIDTH = 32
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] pinLevel,
  input wire logic clearAll,
  output logic [WIDTH-1:0] changeFlags
);
  // Elaboration check: refuse widths the bus word cannot carry
  if (WIDTH < 1 || WIDTH > 32) begin
    $error("change_detect width out of range");
  end

  logic [WIDTH-1:0] prevLevel_q;
  logic primed_q;
  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] edges;
  logic [WIDTH-1:0] flags_d;

  // Either edge counts; no edge seen until one sample is held
  assign edges = primed_q ? (pinLevel ^ prevLevel_q) : '0;
  // A change in the clearing cycle survives the clear
  assign flags_d = (clearAll ? '0 : flags_q) | edges;
  assign changeFlags = flags_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prevLevel_q <= '0;
      primed_q <= 1'b0;
      flags_q <= '0;
    end else begin
      prevLevel_q <= pinLevel;
      primed_q <= 1'b1;
      flags_q <= flags_d;
    end
  end
endmodule

// >>> dv/pin_io_sva.sv
// Checker: bus, pin and interrupt properties of the pin I/O controller
`timescale 1ns/100ps
module pin_io_sva
  import pin_io_pkg::*;
#(
  parameter int PINS = 32
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [pin_io_pkg::ADDR_WIDTH-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic irq,
  input wire logic [PINS-1:0] pinIn,
  input wire logic [PINS-1:0] pinOe_n,
  input wire logic [PINS-1:0] pullupOn,
  input wire logic [PINS-1:0] periphIn
);
  // ----
  // Properties
  // ----
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  wire statusRd = read && waitrequest && address == CHANGE_IRQ_STATUS_OFS;
  wire maskOff = write && waitrequest && address == CHANGE_IRQ_DISABLE_CMD_OFS;
  property p_oneWait;
    $rose(read) || $rose(write) |-> waitrequest ##1 !waitrequest;
  endproperty
  a_oneWait: assert property (p_oneWait) else $error("wait state count wrong");
  property p_resetState;
    $rose(arst_n) |-> pullupOn == '1 && pinOe_n == '1 && !irq;
  endproperty
  a_resetState: assert property (p_resetState) else $error("bad reset state");
  property p_zeroKeeps;
    write && writedata == 32'h0 |=> $stable(pullupOn);
  endproperty
  a_zeroKeeps: assert property (p_zeroKeeps) else $error("zero write changed pull-ups");
  property p_irqHold;
    irq && !statusRd && !maskOff |=> irq;
  endproperty
  a_irqHold: assert property (p_irqHold) else $error("irq dropped early");
  property p_readClear;
    statusRd && $stable(pinIn) |=> !irq;
  endproperty
  a_readClear: assert property (p_readClear) else $error("status read kept irq");
  property p_irqCause;
    $rose(irq) |-> $past(pinIn) != $past(pinIn, 2) || $past(write);
  endproperty
  a_irqCause: assert property (p_irqCause) else $error("irq without cause");
  property p_statusShows;
    statusRd && irq |=> readdata != 32'h0;
  endproperty
  a_statusShows: assert property (p_statusShows) else $error("status empty");
  property p_levelPass;
    periphIn == pinIn;
  endproperty
  a_levelPass: assert property (p_levelPass) else $error("peripheral input differs");
  c_irq: cover property ($rose(irq));
  c_clear: cover property (statusRd && irq);
  c_write: cover property (write && !waitrequest);
endmodule
bind pin_io_controller pin_io_sva #(.PINS(PINS)) sva0 (.clock, .arst_n, .address, .read, .write, .writedata,
  .readdata, .waitrequest, .irq, .pinIn, .pinOe_n, .pullupOn, .periphIn);

// >>> dv/pin_board.sv
// Board model: LEDs, push buttons and pull-ups on the pins
`timescale 1ns/100ps
module pin_board #(
  parameter int PINS = 32
) (
  input wire logic clock,
  input wire logic [PINS-1:0] pinOut,
  input wire logic [PINS-1:0] pinOe_n,
  input wire logic [PINS-1:0] pullupOn,
  input wire logic [PINS-1:0] btnDrive,
  input wire logic [PINS-1:0] btnLevel,
  output logic [PINS-1:0] pinLevel
);
  logic [PINS-1:0] lastQ;
  // Undriven pin without pull-up toggles, so a stale level never passes
  assign pinLevel = (~pinOe_n & pinOut) | (pinOe_n & btnDrive & btnLevel) | (pinOe_n & ~btnDrive & (pullupOn | ~lastQ));
  always_ff @(posedge clock) begin
    lastQ <= pinLevel;
  end
endmodule

// >>> dv/test_pin_io_controller.sv
// Testbench: registers, LEDs, handover and buttons of the pin I/O controller
`timescale 1ns/100ps
module test_pin_io_controller;
  import pin_io_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata, pinIn, pinOut, pinOe_n, pullupOn, periphIn;
  logic waitrequest, irq;
  logic [31:0] periphAOut = 32'h0, periphAOe = 32'h0, periphBOut = 32'hffffffff, periphBOe = 32'h0;
  logic [31:0] btnDrive = 32'h0, btnLevel = 32'h0;
  int num_errors = 0;
  int checks_done = 0;
  // Clock runs from time zero, as if enabled upstream before any sampling
  always #20 clock = ~clock;
  pin_io_controller uut (.clock, .arst_n, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .irq, .pinIn, .pinOut, .pinOe_n, .pullupOn, .periphAOut, .periphAOe, .periphBOut,
    .periphBOe, .periphIn);
  pin_board board (.clock, .pinOut, .pinOe_n, .pullupOn, .btnDrive, .btnLevel, .pinLevel(pinIn));
  // ----
  // Shared tasks
  // ----
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    check({31'h0, waitrequest}, 32'h0);
    if (waitrequest !== 1'b0) summarize();
    // Idle edge keeps back-to-back requests from reassigning a strobe in one step
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    access(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  task automatic waitIrq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 10) begin
      @(posedge clock);
      n++;
    end
    check({31'h0, irq}, 32'h1);
    if (irq !== 1'b1) summarize();
  endtask
  // ----
  // Scenarios
  // ----
  task automatic resetRegs();
    rdChk(GPIO_STATUS_OFS, GPIO_RESET);
    rdChk(OUTPUT_STATUS_OFS, OUTPUT_EN_RESET);
    rdChk(PULLUP_STATUS_OFS, PULLUP_RESET);
    rdChk(PERIPH_SELECT_STATUS_OFS, PERIPH_B_RESET);
    rdChk(CHANGE_IRQ_MASK_OFS, IRQ_MASK_RESET);
    rdChk(8'h2c, UNMAPPED_READ);
    rdChk(PIN_LEVEL_STATUS_OFS, 32'hffffffff);
  endtask
  task automatic leds();
    wr(OUTPUT_ENABLE_CMD_OFS, 32'h3);
    wr(PULLUP_OFF_CMD_OFS, 32'h3);
    wr(SET_OUTPUT_CMD_OFS, 32'h1);
    rdChk(PIN_LEVEL_STATUS_OFS, 32'hfffffffd);
    check(pinOut, 32'h00000001);
    wr(CLEAR_OUTPUT_CMD_OFS, 32'h1);
    wr(SET_OUTPUT_CMD_OFS, 32'h2);
    wr(CLEAR_OUTPUT_CMD_OFS, 32'h0);
    // Lane 0 off: the set of pin 0 must count as zero bits
    byteenable <= 4'he;
    wr(SET_OUTPUT_CMD_OFS, 32'h1);
    byteenable <= 4'hf;
    rdChk(PIN_LEVEL_STATUS_OFS, 32'hfffffffe);
    rdChk(PULLUP_STATUS_OFS, 32'hfffffffc);
    wr(CLEAR_OUTPUT_CMD_OFS, 32'h2);
    wr(PULLUP_ON_CMD_OFS, 32'h2);
    wr(OUTPUT_DISABLE_CMD_OFS, 32'h2);
    rdChk(PIN_LEVEL_STATUS_OFS, 32'hfffffffe);
    check(pinOe_n, 32'hfffffffe);
  endtask
  task automatic handover();
    periphAOe <= 32'h100;
    periphBOe <= 32'h100;
    wr(GPIO_DISABLE_CMD_OFS, 32'h100);
    rdChk(GPIO_STATUS_OFS, 32'hfffffeff);
    rdChk(PIN_LEVEL_STATUS_OFS, 32'hfffffefe);
    check(pinOe_n, 32'hfffffefe);
    wr(PERIPH_B_SELECT_CMD_OFS, 32'h100);
    rdChk(PERIPH_SELECT_STATUS_OFS, 32'h100);
    rdChk(PIN_LEVEL_STATUS_OFS, 32'hfffffffe);
    wr(PERIPH_A_SELECT_CMD_OFS, 32'h100);
    rdChk(PIN_LEVEL_STATUS_OFS, 32'hfffffefe);
    wr(GPIO_ENABLE_CMD_OFS, 32'h100);
    rdChk(PIN_LEVEL_STATUS_OFS, 32'hfffffffe);
  endtask
  task automatic buttons();
    logic [31:0] q;
    access(1'b0, CHANGE_IRQ_STATUS_OFS, 32'h0, q);
    wr(CHANGE_IRQ_ENABLE_CMD_OFS, 32'h10);
    check({31'h0, irq}, 32'h0);
    btnDrive <= 32'h10;
    waitIrq();
    repeat (3) @(posedge clock);
    check({31'h0, irq}, 32'h1);
    rdChk(CHANGE_IRQ_STATUS_OFS, 32'h10);
    check({31'h0, irq}, 32'h0);
    btnDrive <= 32'h0;
    waitIrq();
    rdChk(CHANGE_IRQ_STATUS_OFS, 32'h10);
    wr(CHANGE_IRQ_DISABLE_CMD_OFS, 32'h10);
    btnDrive <= 32'h10;
    repeat (4) @(posedge clock);
    check({31'h0, irq}, 32'h0);
    rdChk(CHANGE_IRQ_STATUS_OFS, 32'h10);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    resetRegs();
    leds();
    handover();
    buttons();
    summarize();
  end
endmodule
